// ### core/dtcp_half.sv
// one 16-bit half: timer, edge count, edge time or pwm
`timescale 1ns/1ps
module dtcp_half #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // configuration
  input  wire logic                 en,
  input  wire logic                 up,
  input  wire logic                 freeze,
  input  wire dtcp_pkg::dtcp_hmode_t mode,
  input  wire logic [1:0]           edge_sel,
  input  wire logic [W-1:0]         load,
  input  wire logic [W-1:0]         match,
  // capture pin
  input  wire logic                 cap_in,
  // results
  output logic [W-1:0]              value,
  output logic                      timeout,
  output logic                      cap_evt,
  output logic                      cap_match,
  output logic                      pwm_raw
);
  logic [W-1:0] cnt;
  logic [W-1:0] cap_reg;
  logic         cap_prev;

  wire rise    = cap_in & ~cap_prev;
  wire fall    = ~cap_in & cap_prev;
  wire evt     = (edge_sel == 2'h0) ? rise : (edge_sel == 2'h1) ? fall : (rise | fall);
  wire is_cnt  = mode == dtcp_pkg::edge_count_capture_mode;
  wire is_time = mode == dtcp_pkg::edge_time_capture_mode;
  wire is_tmr  = mode == dtcp_pkg::hm_one_shot || mode == dtcp_pkg::hm_periodic;
  wire run     = en & ~freeze;
  wire step    = run & (is_cnt ? evt : 1'b1);
  wire [W-1:0] start   = up ? '0 : load;
  wire [W-1:0] term    = up ? load : '0;
  wire         at_term = cnt == term;
  wire [W-1:0] stepped = up ? cnt + 1'b1 : cnt - 1'b1;
  // a finished one-shot holds for one cycle; its cleared enable then preloads start
  wire [W-1:0] next_cnt = !en ? start : !step ? cnt :
                          at_term ? ((mode == dtcp_pkg::hm_one_shot) ? cnt : start) : stepped;

  assign timeout   = step & at_term & is_tmr;
  assign cap_evt   = run & evt & (is_cnt | is_time);
  assign cap_match = step & is_cnt & (stepped == match);
  assign pwm_raw   = up ? (cnt < match) : (cnt > match);
  assign value     = is_time ? cap_reg : cnt;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt      <= '0;
      cap_reg  <= '0;
      cap_prev <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      cap_prev <= cap_in;
      if (run && evt && is_time) begin
        cap_reg <= cnt;
      end
    end
  end

  chk_freeze_hold: assert property (@(posedge clk) disable iff (rst)
    (en && freeze) ##1 en |-> cnt == $past(cnt)) else $error("counter moved while frozen");
  chk_edge_time: assert property (@(posedge clk) disable iff (rst)
    cap_evt && is_time |=> value == $past(cnt)) else $error("edge time not latched");
  chk_edge_select: assert property (@(posedge clk) disable iff (rst)
    (run && is_cnt && edge_sel == 2'h0 && fall) |=> cnt == $past(cnt)) else $error("falling edge counted");
endmodule

// ### core/dtcp_params.svh
// offsets, field positions, reset values and counts of the dual timer
`ifndef DTCP_PARAMS_SVH
`define DTCP_PARAMS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define DTCP_CFG_OFF   8'h00
`define DTCP_HMODE_OFF 8'h04
`define DTCP_CTL_OFF   8'h0C
`define DTCP_LOAD_OFF  8'h10
`define DTCP_MATCH_OFF 8'h18
`define DTCP_VAL_OFF   8'h20
`define DTCP_RIS_OFF   8'h28
`define DTCP_MIS_OFF   8'h2C
`define DTCP_IEN_OFF   8'h30
`define DTCP_ICLR_OFF  8'h34

// ****************************************
// field positions
// ****************************************
`define DTCP_F_UP32  2
`define DTCP_F_UP    3
`define DTCP_F_EDGE  4
`define DTCP_F_INV   6
`define DTCP_F_STALL 7
`define DTCP_F_TRIG  8
`define DTCP_I_TO    0
`define DTCP_I_CM    1
`define DTCP_I_CE    2
`define DTCP_I_RTC   3
`define DTCP_I_HALF  8
`define DTCP_INT_W   11

// ****************************************
// reset values and counts
// ****************************************
`define DTCP_LOAD_RST 32'hFFFF_FFFF
`define DTCP_RTC_DIV  32768

`endif

// ### core/dtcp_pkg.sv
// types shared by the dual timer modules
package dtcp_pkg;
  typedef enum logic [1:0] {gm_one_shot, gm_periodic, gm_rtc, gm_split} dtcp_gmode_t;
  typedef enum logic [2:0] {hm_one_shot, hm_periodic, edge_count_capture_mode,
                            edge_time_capture_mode, hm_pwm} dtcp_hmode_t;
endpackage

// ### core/dtcp_rtc_div.sv
// divider turning the slow clock input into one-second ticks
`timescale 1ns/1ps
module dtcp_rtc_div #(
  parameter int DIV = 32768
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // control and slow clock
  input  wire logic en,
  input  wire logic rtc_in,
  // tick
  output logic      tick
);
  localparam int W = $clog2(DIV);

  logic         prev;
  logic [W-1:0] cnt;
  wire          rise = rtc_in & ~prev;

  always_ff @(posedge clk) begin
    prev <= rtc_in;
    if (rst || !en) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      tick <= rise && cnt == W'(DIV - 1);
      if (rise) begin
        cnt <= (cnt == W'(DIV - 1)) ? '0 : cnt + 1'b1;
      end
    end
  end
endmodule

// ### core/dtcp_top.sv
// dual 16-bit / single 32-bit timer with capture, pwm and rtc, axi4-lite slave
// Overview of operation
// - two 16-bit halves or one 32-bit counter
// - one-shot stops at terminal until re-enabled
// - periodic reloads load value (zero when counting up) and continues
// - 32-bit rtc counts divided one-second ticks
// - capture and pwm only in split arrangement
// - capture counts edges or times them
// - rising, falling or both edges selectable
// - pwm turns capture pin into output
// - capture event and capture match flags
// - timeout per half and rtc match flag
// - up-counting variant for timers and capture
// - independent mode per half when split
// - inversion makes pwm output active low
// - stall setting freezes counter in debug
// - trigger output only when enabled
// - raw and masked interrupt status readable
// - software clear deasserts an interrupt source
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`include "dtcp_params.svh"
module dtcp_top #(
  parameter int ADDR_W  = 8,
  parameter int RTC_DIV = `DTCP_RTC_DIV
) (
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              SYS_RST,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  // capture / pwm pins, index 0 first half, 1 second half
  input  wire logic [1:0]        CCP_IN,
  output logic [1:0]             CCP_OUT,
  output logic [1:0]             CCP_OE,
  // rtc clock and debug halt
  input  wire logic              RTC_CLK_IN,
  input  wire logic              DBG_HALT,
  // trigger and interrupt outputs
  output logic [1:0]             TRIG,
  output logic                   IRQ
);
  localparam int IW = `DTCP_INT_W;

  // ****************************************
  // bus slave
  // ****************************************
  logic [7:0]    waddr;
  logic [31:0]   wdata;
  logic [3:0]    wstrb;
  logic          aw_full;
  logic          w_full;
  logic [2:0]    cfg;
  logic [1:0]    ctl;
  logic [31:0]   cnt32;
  logic [IW-1:0] ris;
  logic [IW-1:0] ien;
  logic [31:0]   rdata;
  logic [8:0]    hcfg_v [2];
  logic [31:0]   hload_v [2];
  logic [31:0]   hmatch_v [2];
  logic [15:0]   val_v [2];
  logic [1:0]    to_h;
  logic [1:0]    cm_h;
  logic [1:0]    ce_h;
  logic [1:0]    os_done;
  logic [1:0]    wr_hmode;

  wire         wr_go   = aw_full & w_full & ~S_AXI_BVALID;
  wire [7:0]   raddr   = {S_AXI_ARADDR[7:2], 2'b00};
  wire         wr_cfg  = wr_go && waddr == `DTCP_CFG_OFF;
  wire         wr_ctl  = wr_go && waddr == `DTCP_CTL_OFF;
  wire         wr_ien  = wr_go && waddr == `DTCP_IEN_OFF;
  wire         wr_iclr = wr_go && waddr == `DTCP_ICLR_OFF;
  wire         w_ok    = waddr <= `DTCP_ICLR_OFF;
  wire         r_ok    = raddr <= `DTCP_ICLR_OFF;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= 2'b00;
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      waddr         <= 8'h00;
      wdata         <= 32'h0000_0000;
      wstrb         <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        waddr         <= {S_AXI_AWADDR[7:2], 2'b00};
        aw_full       <= 1'b1;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        wdata        <= S_AXI_WDATA;
        wstrb        <= S_AXI_WSTRB;
        w_full       <= 1'b1;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_go) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= w_ok ? 2'b00 : 2'b10;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= 2'b00;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= r_ok ? rdata : 32'h0000_0000;
      S_AXI_RRESP   <= r_ok ? 2'b00 : 2'b10;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // ****************************************
  // arrangement and 32-bit counter
  // ****************************************
  wire dtcp_pkg::dtcp_gmode_t gmode = dtcp_pkg::dtcp_gmode_t'(cfg[1:0]);
  wire         split   = gmode == dtcp_pkg::gm_split;
  wire         is_rtc  = gmode == dtcp_pkg::gm_rtc;
  wire         up32    = cfg[`DTCP_F_UP32];
  wire         rtc_tick;
  // the combined counter uses the first half's stall setting and load/match
  wire         run32   = ctl[0] & ~split & ~(hcfg_v[0][`DTCP_F_STALL] & DBG_HALT);
  wire         step32  = run32 & (is_rtc ? rtc_tick : 1'b1);
  wire [31:0]  start32 = (up32 && !is_rtc) ? 32'h0000_0000 : hload_v[0];
  wire [31:0]  term32  = up32 ? hload_v[0] : 32'h0000_0000;
  wire         at_t32  = !is_rtc && cnt32 == term32;
  wire [31:0]  inc32   = cnt32 + 32'h0000_0001;
  wire         to32    = step32 & at_t32;
  wire         rtc_hit = step32 & is_rtc & (inc32 == hmatch_v[0]);
  wire [31:0]  next_cnt32 = !ctl[0] ? start32 : !step32 ? cnt32 : (is_rtc || (up32 && !at_t32)) ? inc32 :
                            !at_t32 ? cnt32 - 32'h0000_0001 :
                            (gmode == dtcp_pkg::gm_one_shot) ? cnt32 : start32;

  dtcp_rtc_div #(
    .DIV (RTC_DIV)
  ) u_rtc_div (
    .clk    (CLK),
    .rst    (SYS_RST),
    .en     (ctl[0] & is_rtc),
    .rtc_in (RTC_CLK_IN),
    .tick   (rtc_tick)
  );

  // ****************************************
  // halves: index 0 is first_half_counter, 1 second_half_counter
  // ****************************************
  for (genvar i = 0; i < 2; i++) begin : g_half
    logic [8:0]  hcfg;
    logic [31:0] hload;
    logic [31:0] hmatch;
    logic        pwm_raw;
    logic        out_q;
    logic        oe_q;
    logic        trig_q;
    wire dtcp_pkg::dtcp_hmode_t hmode = dtcp_pkg::dtcp_hmode_t'(hcfg[2:0]);
    wire         is_pwm  = split && hmode == dtcp_pkg::hm_pwm;
    wire         wr_load = wr_go && waddr == (`DTCP_LOAD_OFF + 8'(4 * i));
    wire         wr_mtch = wr_go && waddr == (`DTCP_MATCH_OFF + 8'(4 * i));
    wire         inv     = hcfg[`DTCP_F_INV];
    wire         tmo     = (i == 0 && !split) ? to32 : to_h[i];
    wire [31:0]  hcfg_m  = merge({23'h00_0000, hcfg}, wdata, wstrb);

    assign wr_hmode[i] = wr_go && waddr == (`DTCP_HMODE_OFF + 8'(4 * i));
    assign os_done[i]  = split ? (to_h[i] && hmode == dtcp_pkg::hm_one_shot) :
                         (i == 0 && to32 && gmode == dtcp_pkg::gm_one_shot);
    assign hcfg_v[i]   = hcfg;
    assign hload_v[i]  = hload;
    assign hmatch_v[i] = hmatch;
    assign CCP_OUT[i]  = out_q;
    assign CCP_OE[i]   = oe_q;
    assign TRIG[i]     = trig_q;

    dtcp_half #(
      .W (16)
    ) u_half_counter (
      .clk       (CLK),
      .rst       (SYS_RST),
      .en        (ctl[i] & split),
      .up        (hcfg[`DTCP_F_UP]),
      .freeze    (hcfg[`DTCP_F_STALL] & DBG_HALT),
      .mode      (hmode),
      .edge_sel  (hcfg[`DTCP_F_EDGE +: 2]),
      .load      (hload[15:0]),
      .match     (hmatch[15:0]),
      .cap_in    (CCP_IN[i]),
      .value     (val_v[i]),
      .timeout   (to_h[i]),
      .cap_evt   (ce_h[i]),
      .cap_match (cm_h[i]),
      .pwm_raw   (pwm_raw)
    );

    always_ff @(posedge CLK) begin
      if (SYS_RST) begin
        hcfg   <= 9'h000;
        hload  <= `DTCP_LOAD_RST;
        hmatch <= 32'h0000_0000;
        out_q  <= 1'b0;
        oe_q   <= 1'b0;
        trig_q <= 1'b0;
      end else begin
        if (wr_hmode[i]) begin
          hcfg <= hcfg_m[8:0];
        end
        if (wr_load) begin
          hload <= merge(hload, wdata, wstrb);
        end
        if (wr_mtch) begin
          hmatch <= merge(hmatch, wdata, wstrb);
        end
        // a stopped pwm rests at its inactive level
        out_q  <= (is_pwm && ctl[i]) ? (pwm_raw ^ inv) : inv;
        oe_q   <= is_pwm;
        trig_q <= hcfg[`DTCP_F_TRIG] & tmo;
      end
    end
  end

  // ****************************************
  // control, interrupts and read mux
  // ****************************************
  logic [IW-1:0] set_v;
  assign set_v = {ce_h[1], cm_h[1], to_h[1], 4'h0, rtc_hit, ce_h[0], cm_h[0], split ? to_h[0] : to32};
  wire [IW-1:0] clr_v    = wr_iclr ? wdata[IW-1:0] & {{3{wstrb[1]}}, {8{wstrb[0]}}} : '0;
  wire [IW-1:0] next_ris = (ris & ~clr_v) | set_v;
  // a new mode leaves the affected counters disabled
  wire [1:0]    mode_clr = {wr_cfg | wr_hmode[1], wr_cfg | wr_hmode[0]};
  wire [31:0]   wr_word  = merge(32'h0000_0000, wdata, wstrb);
  wire [31:0]   ien_m    = merge({21'h00_0000, ien}, wdata, wstrb);
  wire [1:0]    next_ctl = wr_ctl ? wr_word[1:0] : ctl & ~os_done & ~mode_clr;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cfg   <= 3'h0;
      ctl   <= 2'h0;
      cnt32 <= 32'h0000_0000;
      ris   <= '0;
      ien   <= '0;
      IRQ   <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg <= wr_word[2:0];
      end
      if (wr_ien) begin
        ien <= ien_m[IW-1:0];
      end
      ctl   <= next_ctl;
      cnt32 <= next_cnt32;
      ris   <= next_ris;
      IRQ   <= |(ris & ien);
    end
  end

  wire [31:0] mis32 = {21'h00_0000, ris & ien};
  assign rdata = (raddr == `DTCP_CFG_OFF) ? {29'h0000_0000, cfg} :
                 (raddr == `DTCP_HMODE_OFF) ? {23'h00_0000, hcfg_v[0]} :
                 (raddr == `DTCP_HMODE_OFF + 8'h04) ? {23'h00_0000, hcfg_v[1]} :
                 (raddr == `DTCP_CTL_OFF) ? {30'h0000_0000, ctl} :
                 (raddr == `DTCP_LOAD_OFF) ? hload_v[0] :
                 (raddr == `DTCP_LOAD_OFF + 8'h04) ? hload_v[1] :
                 (raddr == `DTCP_MATCH_OFF) ? hmatch_v[0] :
                 (raddr == `DTCP_MATCH_OFF + 8'h04) ? hmatch_v[1] :
                 (raddr == `DTCP_VAL_OFF) ? (split ? {16'h0000, val_v[0]} : cnt32) :
                 (raddr == `DTCP_VAL_OFF + 8'h04) ? {16'h0000, val_v[1]} :
                 (raddr == `DTCP_RIS_OFF) ? {21'h00_0000, ris} :
                 (raddr == `DTCP_MIS_OFF) ? mis32 :
                 (raddr == `DTCP_IEN_OFF) ? {21'h00_0000, ien} : 32'h0000_0000;

  // ****************************************
  // checks
  // ****************************************
  chk_irq_masked: assert property (@(posedge CLK) disable iff (SYS_RST)
    (|(ris & ien)) |=> IRQ) else $error("enabled status did not raise irq");
  chk_set_wins: assert property (@(posedge CLK) disable iff (SYS_RST)
    (set_v[0] && clr_v[0]) |=> ris[0]) else $error("event lost under clear");
  chk_clear_drops: assert property (@(posedge CLK) disable iff (SYS_RST)
    (clr_v[0] && !set_v[0]) |=> !ris[0] ##1 !IRQ || ien[0] == 1'b0 || ris[0]) else $error("clear ignored");
  chk_oneshot_stop: assert property (@(posedge CLK) disable iff (SYS_RST)
    (!split && gmode == dtcp_pkg::gm_one_shot && to32 && !wr_ctl) |=> !ctl[0] && cnt32 == $past(cnt32))
    else $error("one-shot kept running");
  chk_periodic_reload: assert property (@(posedge CLK) disable iff (SYS_RST)
    (run32 && gmode == dtcp_pkg::gm_periodic && !up32 && cnt32 == 32'h0000_0000 && !wr_go)
    |=> cnt32 == $past(hload_v[0])) else $error("periodic reload wrong");
  chk_rtc_match: assert property (@(posedge CLK) disable iff (SYS_RST)
    rtc_hit |=> ris[`DTCP_I_RTC] && cnt32 == hmatch_v[0]) else $error("rtc match not flagged");
  chk_pwm_split: assert property (@(posedge CLK) disable iff (SYS_RST)
    (|CCP_OE) |-> $past(split)) else $error("pwm driven in combined mode");
  chk_trig_gate: assert property (@(posedge CLK) disable iff (SYS_RST)
    TRIG[0] |-> $past(hcfg_v[0][`DTCP_F_TRIG]) && $past(split ? to_h[0] : to32)) else $error("trigger not gated");
  chk_mode_disable: assert property (@(posedge CLK) disable iff (SYS_RST)
    (wr_cfg) |=> ctl == 2'h0) else $error("mode write left counter enabled");
endmodule

// ### verification/dtcp_far_side.sv
// far-side model: capture pin drivers and the slow rtc clock source
`timescale 1ns/1ps
module dtcp_far_side (
  // clock
  input  wire logic       clk,
  // pins as seen by the block
  input  wire logic [1:0] ccp_out,
  input  wire logic [1:0] ccp_oe,
  output logic      [1:0] ccp_in,
  output logic            rtc_clk
);
  logic [1:0] drv;
  // a pin in pwm belongs to the block, so the model lets go of it
  assign ccp_in = (ccp_oe & ccp_out) | (~ccp_oe & drv);
  initial begin
    drv     = 2'b00;
    rtc_clk = 1'b0;
  end
  // one full pulse gives a rising and then a falling edge
  task automatic pulse(input int i, input int hi);
    @(posedge clk);
    drv[i] <= 1'b1;
    repeat (hi) @(posedge clk);
    drv[i] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // slow clock toggles only during a burst and rests low between them
  task automatic rtc_edges(input int n);
    repeat (n) begin
      repeat (3) @(posedge clk);
      rtc_clk <= 1'b1;
      repeat (3) @(posedge clk);
      rtc_clk <= 1'b0;
    end
  endtask
endmodule

// ### verification/tb_top.sv
// self-checking bench for the dual timer with capture, pwm and rtc
`timescale 1ns/1ps
`include "dtcp_params.svh"
module tb_top;
  logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, rtc_clk, dbg_halt, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v, v0;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, wr_r, rd_r, ccp_in, ccp_out, ccp_oe, trig;
  int          error_cnt, n_compared, cyc;

  dtcp_top #(.RTC_DIV(4)) u_dut (.CLK(clk), .SYS_RST(rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .CCP_IN(ccp_in), .CCP_OUT(ccp_out), .CCP_OE(ccp_oe),
    .RTC_CLK_IN(rtc_clk), .DBG_HALT(dbg_halt), .TRIG(trig), .IRQ(irq));
  dtcp_far_side u_far (.clk(clk), .ccp_out(ccp_out), .ccp_oe(ccp_oe), .ccp_in(ccp_in), .rtc_clk(rtc_clk));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  // ****************************************
  // bus and compare helpers
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // each channel is released at its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    int n;
    n = 0;
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && n < 50);
    chk("write answer", 1, 32'(bvalid && bready));
    bready <= 1'b0;
    wr_r = bresp;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && n < 50);
    chk("read answer", 1, 32'(rvalid && rready));
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    @(posedge clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    rd(a, rd_v, rd_r);
    chk(nm, exp, rd_v);
  endtask
  task automatic wait_irq(input int b);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < b) begin
      @(posedge clk);
      n++;
    end
    chk("irq high", 1, irq);
  endtask
  task automatic count20(input int sel, output int c);
    c = 0;
    repeat (20) begin
      @(posedge clk);
      c += (sel == 0) ? trig[0] : ((sel == 1) ? !ccp_out[1] : ccp_out[1]);
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    rc(`DTCP_CFG_OFF, 0, "cfg reset");
    rc(`DTCP_LOAD_OFF, `DTCP_LOAD_RST, "load reset");
    rc(`DTCP_RIS_OFF, 0, "ris reset");
    wr(`DTCP_MATCH_OFF, 32'h1234_5678);
    wr(`DTCP_MATCH_OFF, 32'h0000_00AB, 4'h1);
    rc(`DTCP_MATCH_OFF, 32'h1234_56AB, "match lanes");
    wr(`DTCP_RIS_OFF, 32'hFFFF_FFFF);
    rc(`DTCP_RIS_OFF, 0, "ris read only");
    wr(8'h38, 32'h0000_0001);
    chk("bresp unmapped", 2, wr_r);
    rd(8'h38, rd_v, rd_r);
    chk("rresp unmapped", 2, rd_r);
    $display("test regs done");
  endtask
  task automatic t_periodic();
    wr(`DTCP_CFG_OFF, 1);
    wr(`DTCP_LOAD_OFF, 40);
    wr(`DTCP_IEN_OFF, 1);
    wr(`DTCP_CTL_OFF, 1);
    wait_irq(100);
    rc(`DTCP_MIS_OFF, 1, "mis timeout");
    wr(`DTCP_ICLR_OFF, 1);
    repeat (2) @(posedge clk);
    chk("irq cleared", 0, irq);
    wait_irq(100);
    wr(`DTCP_IEN_OFF, 0);
    repeat (2) @(posedge clk);
    chk("irq masked", 0, irq);
    rc(`DTCP_MIS_OFF, 0, "mis masked");
    rc(`DTCP_RIS_OFF, 1, "ris raw");
    wr(`DTCP_CFG_OFF, 1);
    rc(`DTCP_CTL_OFF, 0, "ctl after cfg");
    $display("test periodic done");
  endtask
  task automatic t_oneshot();
    wr(`DTCP_CFG_OFF, 4);
    wr(`DTCP_LOAD_OFF, 3);
    wr(`DTCP_ICLR_OFF, 32'h0000_07FF);
    wr(`DTCP_CTL_OFF, 1);
    repeat (20) @(posedge clk);
    rc(`DTCP_CTL_OFF, 0, "oneshot stopped");
    rc(`DTCP_VAL_OFF, 0, "up preload");
    wr(`DTCP_ICLR_OFF, 1);
    repeat (20) @(posedge clk);
    rc(`DTCP_RIS_OFF, 0, "no restart");
    $display("test oneshot done");
  endtask
  task automatic t_capture();
    int e, c0;
    wr(`DTCP_CFG_OFF, 3);
    for (e = 0; e < 3; e++) begin
      wr(`DTCP_HMODE_OFF, 32'(2 + 16 * e));
      wr(`DTCP_LOAD_OFF, 10);
      wr(`DTCP_MATCH_OFF, 8);
      wr(`DTCP_ICLR_OFF, 32'h0000_07FF);
      wr(`DTCP_CTL_OFF, 1);
      u_far.pulse(0, 4);
      u_far.pulse(0, 4);
      rc(`DTCP_VAL_OFF, 32'((e == 2) ? 6 : 8), "edge count");
      rc(`DTCP_RIS_OFF, 32'h0000_0006, "capture flags");
    end
    wr(`DTCP_HMODE_OFF + 8'h04, 32'h0000_000B);
    wr(`DTCP_LOAD_OFF + 8'h04, 32'h0000_FFFF);
    wr(`DTCP_CTL_OFF, 3);
    c0 = cyc;
    u_far.pulse(1, 2);
    rd(`DTCP_VAL_OFF + 8'h04, v0, rd_r);
    repeat (7) @(posedge clk);
    c0 = cyc - c0;
    u_far.pulse(1, 2);
    rd(`DTCP_VAL_OFF + 8'h04, rd_v, rd_r);
    chk("edge time", 32'(c0), rd_v - v0);
    rc(`DTCP_RIS_OFF, 32'h0000_0406, "event second");
    $display("test capture done");
  endtask
  task automatic t_pwm_trig();
    int c;
    wr(`DTCP_HMODE_OFF, 32'h0000_0101);
    wr(`DTCP_LOAD_OFF, 4);
    wr(`DTCP_HMODE_OFF + 8'h04, 32'h0000_0044);
    wr(`DTCP_LOAD_OFF + 8'h04, 9);
    wr(`DTCP_MATCH_OFF + 8'h04, 3);
    wr(`DTCP_CTL_OFF, 3);
    repeat (4) @(posedge clk);
    chk("pin enables", 2, ccp_oe);
    count20(0, c);
    chk("trigger count", 4, c);
    count20(1, c);
    chk("inverted low", 12, c);
    wr(`DTCP_HMODE_OFF, 1);
    wr(`DTCP_HMODE_OFF + 8'h04, 4);
    wr(`DTCP_CTL_OFF, 3);
    count20(0, c);
    chk("trigger off", 0, c);
    count20(2, c);
    chk("plain high", 12, c);
    wr(`DTCP_CFG_OFF, 1);
    repeat (2) @(posedge clk);
    chk("no pwm in 32", 0, ccp_oe);
    $display("test pwm done");
  endtask
  task automatic t_stall();
    wr(`DTCP_CFG_OFF, 3);
    wr(`DTCP_HMODE_OFF, 32'h0000_0081);
    wr(`DTCP_LOAD_OFF, 32'h0000_FFFF);
    wr(`DTCP_CTL_OFF, 1);
    dbg_halt <= 1'b1;
    repeat (2) @(posedge clk);
    rd(`DTCP_VAL_OFF, v0, rd_r);
    rc(`DTCP_VAL_OFF, v0, "frozen");
    wr(`DTCP_HMODE_OFF, 1);
    wr(`DTCP_CTL_OFF, 1);
    rd(`DTCP_VAL_OFF, v0, rd_r);
    rd(`DTCP_VAL_OFF, rd_v, rd_r);
    chk("runs in halt", 1, 32'(rd_v != v0));
    dbg_halt <= 1'b0;
    $display("test stall done");
  endtask
  task automatic t_rtc();
    wr(`DTCP_CFG_OFF, 2);
    wr(`DTCP_LOAD_OFF, 0);
    wr(`DTCP_MATCH_OFF, 2);
    wr(`DTCP_ICLR_OFF, 32'h0000_07FF);
    wr(`DTCP_IEN_OFF, 8);
    wr(`DTCP_CTL_OFF, 1);
    u_far.rtc_edges(4);
    repeat (4) @(posedge clk);
    rc(`DTCP_VAL_OFF, 1, "one tick");
    rc(`DTCP_RIS_OFF, 0, "no match yet");
    u_far.rtc_edges(4);
    wait_irq(8);
    rc(`DTCP_RIS_OFF, 8, "rtc match");
    $display("test rtc done");
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
  initial begin
    rst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000; wstrb = 4'hF; dbg_halt = 1'b0;
    error_cnt = 0; n_compared = 0; cyc = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_periodic();
    t_oneshot();
    t_capture();
    t_pwm_trig();
    t_stall();
    t_rtc();
    wrap_up();
  end
endmodule
